/* File: hdl/bdcp_pkg.sv */
package bdcp_pkg;

    localparam int ADDR_W      = 24;
    localparam int DATA_W      = 32;
    localparam int TX_BYTES    = 5;
    localparam int TX_CNT_W    = 3;
    localparam int REG_ADDR_W  = 4;
    localparam int REG_DATA_W  = 16;

    // boot mode strap encodings
    localparam logic MODE_NORMAL  = 1'b1;
    localparam logic MODE_SPECIAL = 1'b0;

    // single opcodes
    localparam logic [7:0] OP_NOP         = 8'h00;
    localparam logic [7:0] OP_SAMPLE_PC   = 8'h01;
    localparam logic [7:0] OP_BACKGROUND  = 8'h04;
    localparam logic [7:0] OP_GO          = 8'h08;
    localparam logic [7:0] OP_READ_STATUS = 8'h2d;

    // memory opcode families: [7:4] family, [3:2] size, [1] direction, [0] with status
    localparam logic [3:0] FAM_FILL      = 4'h1;
    localparam logic [3:0] FAM_READ_DUMP = 4'h3;
    localparam logic [3:0] FAM_READ_SAME = 4'h5;
    localparam int         OPC_WS_BIT    = 0;
    localparam int         OPC_DIR_BIT   = 1;
    localparam int         OPC_SZ_LSB    = 2;

    localparam logic [7:0] ILL_RESP_BYTE = 8'hff;
    localparam logic [7:0] NO_RESPONSE_FLAG_BYTE   = 8'hee;
    localparam logic [2:0] ADDR_BYTES    = 3'h3;

    // register offsets
    localparam logic [REG_ADDR_W-1:0] REG_INT_STATUS = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_INT_MASK   = 4'h1;
    localparam logic [REG_ADDR_W-1:0] REG_CONTROL    = 4'h2;
    localparam logic [REG_ADDR_W-1:0] REG_DBG_STATUS = 4'h3;

    // event bits of status, mask and debug status
    localparam int EV_ILLEGAL = 0;
    localparam int EV_NO_RESPONSE_FLAG  = 1;
    localparam int EV_W       = 2;
    // control bits
    localparam int CTL_ACK_EN = 0;
    localparam int CTL_KEEP   = 1;
    localparam int CTL_BDM    = 2;
    // debug status bits above the events
    localparam int DS_ACK_EN  = 2;
    localparam int DS_KEEP    = 3;
    localparam int DS_BDM     = 4;
    localparam int DS_MODE    = 5;
    localparam int DS_STOP    = 6;

    // sample timeout
    localparam int PC_TIMEOUT_NS = 1000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PC_TIMEOUT_CYC = (PC_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_LONG,
        SZ_RSVD
    } bdcp_size_type;

    typedef struct packed {
        logic              we;
        bdcp_size_type     size;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bdcp_mem_req_type;

endpackage

/* File: hdl/bdcp_resp_tx.sv */
`timescale 1ns/1ps
`default_nettype none

module bdcp_resp_tx
    import bdcp_pkg::*;
#(
    parameter int BYTES = TX_BYTES,
    parameter int CNT_W = TX_CNT_W
) (
    input  wire logic               i_core_clk,
    input  wire logic               i_rst,
    input  wire logic               i_load,
    input  wire logic [8*BYTES-1:0] i_data,
    input  wire logic [CNT_W-1:0]   i_count,
    input  wire logic               i_ready,
    output logic                    o_valid,
    output logic [7:0]              o_byte,
    output logic                    o_busy
);

    logic [8*BYTES-1:0] shift_reg;
    logic [CNT_W-1:0]   left_reg;
    wire                take = o_valid & i_ready;

    // msb first; the head byte is always a flop
    assign o_valid = (left_reg != '0);
    assign o_busy  = o_valid;
    assign o_byte  = shift_reg[8*BYTES-1 -: 8];

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            shift_reg <= '0;
            left_reg  <= '0;
        end else if (i_load) begin
            shift_reg <= i_data;
            left_reg  <= i_count;
        end else if (take) begin
            shift_reg <= {shift_reg[8*BYTES-9:0], 8'h00};
            left_reg  <= left_reg - 1'b1;
        end
    end

endmodule

`default_nettype wire

/* File: hdl/bdcp_core.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - latch boot mode strap at reset release
// - special mode leaves reset in debug state
// - debug state via command, control register write or special boot
// - commands still served during processor stop
// - dump only after sync, nop, read, dump
// - nop never changes the address pointer
// - size field decoded on every dump
// - fill writes at pointer then advances it
// - fill with status replies status low byte
// - repeat read returns last single-read address
// - repeat read only after sync, nop, read, repeat
// - acknowledge pulse precedes returned data bytes
// - status command returns sixteen bits, any mode
// - program counter sample returns three bytes
// - sample timeout returns 0xee, sets flag
// - outside debug state, timeout on wait, stop unkept, external wait
// - outside debug state, kept stop returns address after stop
// - otherwise returns current instruction address
module bdcp_core
    import bdcp_pkg::*;
#(
    parameter int TIMEOUT_CYC = PC_TIMEOUT_CYC
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_boot_mode_select,
    input  wire logic                  i_sync,
    input  wire logic                  i_host_valid,
    input  wire logic [7:0]            i_host_byte,
    output logic                       o_host_ready,
    output logic                       o_tgt_valid,
    output logic [7:0]                 o_tgt_byte,
    input  wire logic                  i_tgt_ready,
    output logic                       o_ack,
    output logic                       o_mem_req,
    output bdcp_mem_req_type           o_mem,
    input  wire logic                  i_mem_ack,
    input  wire logic [DATA_W-1:0]     i_mem_rdata,
    output logic                       o_pc_req,
    input  wire logic                  i_pc_ack,
    input  wire logic [ADDR_W-1:0]     i_cpu_pc,
    input  wire logic [ADDR_W-1:0]     i_cpu_next_pc,
    input  wire logic                  i_cpu_wait_instr,
    input  wire logic                  i_cpu_stop,
    input  wire logic                  i_external_wait,
    input  wire logic [REG_ADDR_W-1:0] i_reg_addr,
    input  wire logic [REG_DATA_W-1:0] i_reg_wdata,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    output logic [REG_DATA_W-1:0]      o_reg_rdata,
    output logic                       o_irq,
    output logic                       o_background_debug_state,
    output logic                       o_boot_mode
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_MEM,
        ST_PC,
        ST_RESP,
        ST_TX
    } bdcp_state_type;

    typedef enum logic [1:0] {
        K_READ,
        K_DUMP,
        K_SAME,
        K_FILL
    } bdcp_kind_type;

    localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

    bdcp_state_type       state_reg, state_next;
    bdcp_kind_type        kind_reg, kind_next;
    bdcp_size_type        sz_reg, sz_next;
    logic                 ws_reg, ws_next;
    logic [2:0]           rx_cnt_reg, rx_cnt_next;
    logic [2:0]           rx_need_reg, rx_need_next;
    logic [23:0]          wbuf_reg, wbuf_next;
    logic [ADDR_W-1:0]    addr_reg, addr_next;
    logic [ADDR_W-1:0]    same_addr_reg, same_addr_next;
    logic                 dump_ok_reg, dump_ok_next;
    logic                 same_ok_reg, same_ok_next;
    bdcp_mem_req_type     mem_reg, mem_next;
    logic [8*TX_BYTES-1:0] txd_reg, txd_next;
    logic [TX_CNT_W-1:0]  txc_reg, txc_next;
    logic [TO_W-1:0]      to_cnt_reg, to_cnt_next;
    logic                 bdm_reg, bdm_next;
    logic                 mode_reg;
    logic                 ack_en_reg, keep_reg;
    logic [EV_W-1:0]      int_stat_reg, int_mask_reg;
    logic [REG_DATA_W-1:0] rdata_reg;
    logic                 ill_set, nr_set, tx_load, tx_busy;

    // opcode field decode
    wire [3:0]  op_fam  = i_host_byte[7:4];
    wire        op_dir  = i_host_byte[OPC_DIR_BIT];
    wire        op_ws   = i_host_byte[OPC_WS_BIT];
    wire [1:0]  op_sz   = i_host_byte[OPC_SZ_LSB +: 2];
    wire        is_read = (op_fam == FAM_READ_DUMP) & op_dir;
    wire        is_dump = (op_fam == FAM_READ_DUMP) & ~op_dir;
    wire        is_same = (op_fam == FAM_READ_SAME) & ~op_dir;
    wire        is_fill = (op_fam == FAM_FILL) & op_dir;
    wire        host_take = i_host_valid & o_host_ready;

    wire [2:0]  size_bytes = (sz_reg == SZ_BYTE) ? 3'h1 :
                             (sz_reg == SZ_WORD) ? 3'h2 : 3'h4;
    wire [2:0]  op_bytes   = (op_sz == 2'(SZ_BYTE)) ? 3'h1 :
                             (op_sz == 2'(SZ_WORD)) ? 3'h2 : 3'h4;
    wire [2:0]  data_n     = (kind_reg == K_FILL) ? 3'h0 : size_bytes;
    wire [5:0]  resp_sh    = 6'(6'd32 - {data_n, 3'b000});

    wire [REG_DATA_W-1:0] dbg_status = {
        9'h000, i_cpu_stop, mode_reg, bdm_reg, keep_reg, ack_en_reg,
        int_stat_reg[EV_NO_RESPONSE_FLAG], int_stat_reg[EV_ILLEGAL]};

    // data left aligned, status low byte just after it
    wire [DATA_W-1:0]     rd_just = i_mem_rdata << resp_sh;
    wire [8*TX_BYTES-1:0] st_slot = {32'h0, dbg_status[7:0]} << resp_sh;
    wire [8*TX_BYTES-1:0] mem_resp = {rd_just, 8'h00} | (ws_reg ? st_slot : 40'h0);

    // stalls never answer, so the counter runs out
    wire pc_stalled = i_cpu_wait_instr | (i_cpu_stop & ~keep_reg) | i_external_wait;
    wire pc_timeout = (to_cnt_reg == TO_W'(TIMEOUT_CYC - 1));

    wire wr_int  = i_reg_wr & (i_reg_addr == REG_INT_STATUS);
    wire wr_mask = i_reg_wr & (i_reg_addr == REG_INT_MASK);
    wire wr_ctl  = i_reg_wr & (i_reg_addr == REG_CONTROL);

    wire [REG_DATA_W-1:0] rd_mux =
        (i_reg_addr == REG_INT_STATUS) ? REG_DATA_W'(int_stat_reg) :
        (i_reg_addr == REG_INT_MASK)   ? REG_DATA_W'(int_mask_reg) :
        (i_reg_addr == REG_CONTROL)    ? REG_DATA_W'({bdm_reg, keep_reg, ack_en_reg}) :
        (i_reg_addr == REG_DBG_STATUS) ? dbg_status : '0;

    // no stop gating: host served while the processor sleeps
    assign o_host_ready = (state_reg == ST_IDLE) | (state_reg == ST_RX);
    assign o_mem_req    = (state_reg == ST_MEM);
    assign o_mem        = mem_reg;
    assign o_pc_req     = (state_reg == ST_PC);
    assign o_ack        = (state_reg == ST_RESP) & ack_en_reg;
    assign o_irq        = |(int_stat_reg & int_mask_reg);
    assign o_reg_rdata  = rdata_reg;
    assign o_background_debug_state = bdm_reg;
    assign o_boot_mode  = mode_reg;

    always_comb begin
        state_next     = state_reg;
        kind_next      = kind_reg;
        sz_next        = sz_reg;
        ws_next        = ws_reg;
        rx_cnt_next    = rx_cnt_reg;
        rx_need_next   = rx_need_reg;
        wbuf_next      = wbuf_reg;
        addr_next      = addr_reg;
        same_addr_next = same_addr_reg;
        dump_ok_next   = dump_ok_reg;
        same_ok_next   = same_ok_reg;
        mem_next       = mem_reg;
        txd_next       = txd_reg;
        txc_next       = txc_reg;
        to_cnt_next    = to_cnt_reg;
        bdm_next       = bdm_reg;
        ill_set        = 1'b0;
        nr_set         = 1'b0;
        tx_load        = 1'b0;
        if (wr_ctl && i_reg_wdata[CTL_BDM]) begin
            bdm_next = 1'b1;
        end
        case (state_reg)
            ST_IDLE: begin
                if (i_sync) begin
                    dump_ok_next = 1'b1;
                    same_ok_next = 1'b1;
                end else if (host_take) begin
                    sz_next      = bdcp_size_type'(op_sz);
                    ws_next      = op_ws;
                    rx_cnt_next  = 3'h0;
                    wbuf_next    = '0;
                    dump_ok_next = 1'b0;
                    same_ok_next = 1'b0;
                    if (i_host_byte == OP_NOP) begin
                        // pointer untouched, chaining stays open
                        dump_ok_next = 1'b1;
                        same_ok_next = 1'b1;
                    end else if (i_host_byte == OP_SAMPLE_PC) begin
                        to_cnt_next = '0;
                        state_next  = ST_PC;
                    end else if (i_host_byte == OP_READ_STATUS) begin
                        txd_next   = {dbg_status, 24'h000000};
                        txc_next   = 3'h2;
                        state_next = ST_RESP;
                    end else if (i_host_byte == OP_BACKGROUND) begin
                        bdm_next = 1'b1;
                    end else if (i_host_byte == OP_GO) begin
                        bdm_next = 1'b0;
                    end else if (is_read) begin
                        kind_next    = K_READ;
                        rx_need_next = ADDR_BYTES;
                        state_next   = ST_RX;
                    end else if (is_fill) begin
                        kind_next    = K_FILL;
                        rx_need_next = op_bytes;
                        state_next   = ST_RX;
                    end else if (is_dump && dump_ok_reg) begin
                        kind_next  = K_DUMP;
                        mem_next   = '{we: 1'b0, size: bdcp_size_type'(op_sz),
                                       addr: addr_reg, wdata: '0};
                        state_next = ST_MEM;
                    end else if (is_same && same_ok_reg) begin
                        kind_next  = K_SAME;
                        mem_next   = '{we: 1'b0, size: bdcp_size_type'(op_sz),
                                       addr: same_addr_reg, wdata: '0};
                        state_next = ST_MEM;
                    end else begin
                        ill_set    = 1'b1;
                        txd_next   = {ILL_RESP_BYTE, 32'h0};
                        txc_next   = 3'h1;
                        state_next = ST_RESP;
                    end
                end
            end
            ST_RX: begin
                if (host_take) begin
                    wbuf_next   = {wbuf_reg[15:0], i_host_byte};
                    rx_cnt_next = rx_cnt_reg + 3'h1;
                    if (rx_cnt_reg + 3'h1 == rx_need_reg) begin
                        state_next = ST_MEM;
                        if (kind_reg == K_READ) begin
                            addr_next      = {wbuf_reg[15:0], i_host_byte};
                            same_addr_next = {wbuf_reg[15:0], i_host_byte};
                            mem_next = '{we: 1'b0, size: sz_reg,
                                         addr: {wbuf_reg[15:0], i_host_byte}, wdata: '0};
                        end else begin
                            mem_next = '{we: 1'b1, size: sz_reg, addr: addr_reg,
                                         wdata: {wbuf_reg, i_host_byte}};
                        end
                    end
                end
            end
            ST_MEM: begin
                if (i_mem_ack) begin
                    if (kind_reg == K_DUMP || kind_reg == K_FILL) begin
                        addr_next = addr_reg + ADDR_W'(size_bytes);
                    end
                    dump_ok_next = (kind_reg == K_READ) | (kind_reg == K_DUMP);
                    same_ok_next = (kind_reg == K_READ) | (kind_reg == K_SAME);
                    txd_next   = mem_resp;
                    txc_next   = data_n + {2'b00, ws_reg};
                    state_next = ST_RESP;
                end
            end
            ST_PC: begin
                to_cnt_next = to_cnt_reg + TO_W'(1);
                txc_next    = 3'h3;
                if (bdm_reg) begin
                    txd_next   = {i_cpu_pc, 16'h0000};
                    state_next = ST_RESP;
                end else if (i_cpu_stop && keep_reg) begin
                    txd_next   = {i_cpu_next_pc, 16'h0000};
                    state_next = ST_RESP;
                end else if (i_pc_ack && !pc_stalled) begin
                    txd_next   = {i_cpu_pc, 16'h0000};
                    state_next = ST_RESP;
                end else if (pc_timeout) begin
                    nr_set     = 1'b1;
                    txd_next   = {NO_RESPONSE_FLAG_BYTE, NO_RESPONSE_FLAG_BYTE, NO_RESPONSE_FLAG_BYTE, 16'h0000};
                    state_next = ST_RESP;
                end
            end
            ST_RESP: begin
                // acknowledge shows here, bytes start the cycle after
                tx_load    = 1'b1;
                state_next = ST_TX;
            end
            ST_TX: begin
                if (!tx_busy) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    bdcp_resp_tx #(
        .BYTES (TX_BYTES),
        .CNT_W (TX_CNT_W)
    ) u_resp_tx (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_load     (tx_load),
        .i_data     (txd_reg),
        .i_count    (txc_reg),
        .i_ready    (i_tgt_ready),
        .o_valid    (o_tgt_valid),
        .o_byte     (o_tgt_byte),
        .o_busy     (tx_busy)
    );

    // strap followed during reset; last value before release wins
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mode_reg <= i_boot_mode_select;
            bdm_reg  <= (i_boot_mode_select == MODE_SPECIAL);
        end else begin
            bdm_reg  <= bdm_next;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg     <= ST_IDLE;
            kind_reg      <= K_READ;
            sz_reg        <= SZ_BYTE;
            ws_reg        <= 1'b0;
            rx_cnt_reg    <= 3'h0;
            rx_need_reg   <= 3'h0;
            wbuf_reg      <= 24'h000000;
            addr_reg      <= '0;
            same_addr_reg <= '0;
            dump_ok_reg   <= 1'b0;
            same_ok_reg   <= 1'b0;
            mem_reg       <= '0;
            txd_reg       <= '0;
            txc_reg       <= '0;
            to_cnt_reg    <= '0;
        end else begin
            state_reg     <= state_next;
            kind_reg      <= kind_next;
            sz_reg        <= sz_next;
            ws_reg        <= ws_next;
            rx_cnt_reg    <= rx_cnt_next;
            rx_need_reg   <= rx_need_next;
            wbuf_reg      <= wbuf_next;
            addr_reg      <= addr_next;
            same_addr_reg <= same_addr_next;
            dump_ok_reg   <= dump_ok_next;
            same_ok_reg   <= same_ok_next;
            mem_reg       <= mem_next;
            txd_reg       <= txd_next;
            txc_reg       <= txc_next;
            to_cnt_reg    <= to_cnt_next;
        end
    end

    // a new event outranks a same-cycle write-one-to-clear
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            int_stat_reg <= '0;
            int_mask_reg <= '0;
            ack_en_reg   <= 1'b0;
            keep_reg     <= 1'b0;
            rdata_reg    <= '0;
        end else begin
            int_stat_reg <= (int_stat_reg & ~(wr_int ? i_reg_wdata[EV_W-1:0] : 2'b00))
                          | {nr_set, ill_set};
            if (wr_mask) begin
                int_mask_reg <= i_reg_wdata[EV_W-1:0];
            end
            if (wr_ctl) begin
                ack_en_reg <= i_reg_wdata[CTL_ACK_EN];
                keep_reg   <= i_reg_wdata[CTL_KEEP];
            end
            rdata_reg <= i_reg_rd ? rd_mux : '0;
        end
    end

endmodule

`default_nettype wire

/* File: verif/bdcp_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module bdcp_core_asserts
    import bdcp_pkg::*;
#(
    parameter int TIMEOUT_CYC = 8
) (
    input wire logic                  i_core_clk, i_rst, i_boot_mode_select, o_boot_mode,
    input wire logic                  o_background_debug_state, o_host_ready, o_tgt_valid,
    input wire logic                  i_tgt_ready, o_ack, o_mem_req, i_mem_ack, o_pc_req,
    input wire logic                  i_pc_ack, i_cpu_wait_instr, i_cpu_stop, i_external_wait,
    input wire logic                  i_reg_rd,
    input wire logic [7:0]            o_tgt_byte,
    input wire bdcp_mem_req_type      o_mem,
    input wire logic [REG_DATA_W-1:0] o_reg_rdata
);
    logic [15:0] pc_cnt;
    // too long to unroll as a repetition
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !o_pc_req) pc_cnt <= 16'h0000;
        else pc_cnt <= pc_cnt + 16'h0001;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_boot_mode_latch: assert property (
        $fell(i_rst) |-> o_boot_mode == $past(i_boot_mode_select))
        else $error("boot mode not taken from strap");
    a_special_boot_debug: assert property (
        $fell(i_rst) |-> o_background_debug_state == !o_boot_mode)
        else $error("debug state wrong after reset");
    a_ack_before_data: assert property (o_ack |-> !o_tgt_valid)
        else $error("acknowledge overlaps reply byte");
    a_reply_byte_held: assert property (
        o_tgt_valid && !i_tgt_ready |=> o_tgt_valid && $stable(o_tgt_byte))
        else $error("reply byte dropped before taken");
    a_mem_req_held: assert property (
        o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem))
        else $error("memory request changed while pending");
    a_host_refused: assert property (o_tgt_valid |-> !o_host_ready)
        else $error("host byte accepted during reply");
    a_sample_bounded: assert property (o_pc_req |-> pc_cnt < 16'(TIMEOUT_CYC + 4))
        else $error("sample outlived its timeout");
    a_sample_answered: assert property (
        o_pc_req && i_pc_ack && !i_cpu_wait_instr && !i_cpu_stop && !i_external_wait
        |=> !o_pc_req) else $error("sample ignored processor answer");
    a_rdata_idle_zero: assert property (!$past(i_reg_rd) |-> o_reg_rdata == '0)
        else $error("read data outside read cycle");
    c_ack: cover property (o_ack);
    c_sample: cover property ($rose(o_pc_req));
    c_fill: cover property (o_mem_req && o_mem.we && i_mem_ack);
endmodule
bind bdcp_core bdcp_core_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) bdcp_core_asserts_i (.*);
`default_nettype wire

/* File: verif/bdcp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bdcp_host_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_host_ready,
    input  wire logic       i_tgt_valid,
    input  wire logic [7:0] i_tgt_byte,
    output logic            o_valid = 1'b0,
    output logic [7:0]      o_byte = 8'h00,
    output logic            o_ready = 1'b0
);
    // opcode, then operands msb first
    task automatic cmd(input logic [7:0] q[$]);
        @(posedge i_core_clk);
        foreach (q[k]) begin
            o_valid <= 1'b1;
            o_byte <= q[k];
            do @(negedge i_core_clk); while (!i_host_ready);
            @(posedge i_core_clk);
        end
        o_valid <= 1'b0;
        o_byte <= ~q[q.size()-1];
    endtask
    // slow: idle cycles before the reply
    task automatic recv(input int n, input int slow, output logic [31:0] v);
        v = 32'h0;
        repeat (slow) @(posedge i_core_clk);
        if (n == 0) return;
        @(posedge i_core_clk);
        o_ready <= 1'b1;
        repeat (n) begin
            do @(negedge i_core_clk); while (!i_tgt_valid);
            v = {v[23:0], i_tgt_byte};
            @(posedge i_core_clk);
        end
        o_ready <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_background_debug_command_port.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module tb_background_debug_command_port
    import bdcp_pkg::*;
;
    logic             h_valid, h_ready, t_valid, t_ready, ack_o, mreq, preq, irq;
    logic             rst = 1'b1, strap = 1'b0, mack = 1'b0, pack = 1'b0, sync = 1'b0, bds, mode;
    logic             clk = 1'b0, wt = 1'b0, stp = 1'b0, ewt = 1'b0, rwr = 1'b0, rrd = 1'b0;
    logic [7:0]       h_byte, t_byte;
    logic [3:0]       raddr = 4'h0;
    logic [15:0]      wdat = 16'h0000, rdat;
    logic [23:0]      pc = 24'h123456, la;
    logic [31:0]      wd;
    bdcp_mem_req_type mem;
    int               mismatches = 0, tests_run = 0, acks = 0;
    bdcp_core #(.TIMEOUT_CYC(8)) bdcp_core_i (
        .i_core_clk(clk), .i_rst(rst), .i_boot_mode_select(strap), .i_sync(sync),
        .i_host_valid(h_valid), .i_host_byte(h_byte), .o_host_ready(h_ready),
        .o_tgt_valid(t_valid), .o_tgt_byte(t_byte), .i_tgt_ready(t_ready), .o_ack(ack_o),
        .o_mem_req(mreq), .o_mem(mem), .i_mem_ack(mack), .i_mem_rdata({8'ha5, mem.addr}),
        .o_pc_req(preq), .i_pc_ack(pack), .i_cpu_pc(pc), .i_cpu_next_pc(pc + 24'h000004),
        .i_cpu_wait_instr(wt), .i_cpu_stop(stp), .i_external_wait(ewt), .i_reg_addr(raddr),
        .i_reg_wdata(wdat), .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdat), .o_irq(irq),
        .o_background_debug_state(bds), .o_boot_mode(mode));
    bdcp_host_model bdcp_host_model_i (.i_core_clk(clk), .i_host_ready(h_ready),
        .i_tgt_valid(t_valid), .i_tgt_byte(t_byte), .o_valid(h_valid), .o_byte(h_byte),
        .o_ready(t_ready));
    initial forever #2.5 clk = ~clk;
    // answers one cycle after each request
    always @(posedge clk) begin
        mack <= mreq && !mack;
        pack <= preq && !pack;
        acks <= acks + int'(ack_o);
        if (mreq && mack) la <= mem.addr;
        if (mreq && mack && mem.we) wd <= mem.wdata;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        raddr <= a;
        wdat <= d;
        rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        raddr <= a;
        rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        @(negedge clk);
        `CHK(rdat, e)
    endtask
    task automatic xfer(input logic [7:0] q[$], input int n, input logic [31:0] e,
                        input int slow = 0);
        logic [31:0] r;
        bdcp_host_model_i.cmd(q);
        bdcp_host_model_i.recv(n, slow, r);
        `CHK(r, e)
    endtask
    task automatic reset_to(input logic s);
        @(posedge clk);
        rst <= 1'b1;
        strap <= s;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK({mode, bds}, {s, ~s})
    endtask
    task automatic t_pc();
        xfer('{OP_BACKGROUND}, 0, 32'h0);
        rd(REG_DBG_STATUS, 16'h0030);
        xfer('{OP_GO}, 0, 32'h0);
        for (int k = 0; k < 3; k++) begin
            {ewt, wt, stp} <= 3'(1 << k);
            xfer('{OP_SAMPLE_PC}, 3, 32'h00eeeeee, k);
        end
        {ewt, wt, stp} <= 3'h0;
        rd(REG_INT_STATUS, 16'h0002);
        wr(REG_INT_STATUS, 16'h0003);
        wr(REG_CONTROL, 16'h0002);
        xfer('{OP_SAMPLE_PC}, 3, {8'h00, pc});
        stp <= 1'b1;
        xfer('{OP_SAMPLE_PC}, 3, {8'h00, pc + 24'h000004});
        stp <= 1'b0;
    endtask
    task automatic t_mem();
        int a0;
        wr(REG_CONTROL, 16'h0005);
        rd(REG_DBG_STATUS, 16'h0034);
        a0 = acks;
        xfer('{8'h32, 8'h01, 8'h02, 8'h10}, 1, 32'h00000010);
        `CHK(acks - a0, 1)
        xfer('{OP_NOP}, 0, 32'h0);
        xfer('{8'h30}, 1, 32'h00000010);
        xfer('{8'h34}, 2, 32'h00000211);
        xfer('{8'h38}, 4, 32'ha5010213);
        xfer('{8'h17, 8'hbe, 8'hef}, 1, 32'h00000034);
        `CHK({la, wd}, {24'h010217, 32'h0000beef})
        xfer('{8'h13, 8'h5a}, 1, 32'h00000034);
        `CHK({la, wd}, {24'h010219, 32'h0000005a})
    endtask
    task automatic t_chain();
        wr(REG_INT_MASK, 16'h0001);
        xfer('{8'h50}, 1, 32'h000000ff);
        xfer('{8'h30}, 1, 32'h000000ff, 2);
        @(negedge clk);
        `CHK(irq, 1'b1)
        wr(REG_INT_STATUS, 16'h0001);
        @(negedge clk);
        `CHK(irq, 1'b0)
        @(posedge clk);
        sync <= 1'b1;
        @(posedge clk);
        sync <= 1'b0;
        xfer('{8'h30}, 1, 32'h0000001a);
        xfer('{8'h36, 8'h02, 8'h03, 8'h04}, 2, 32'h00000304);
        xfer('{8'h54}, 2, 32'h00000304, 3);
        xfer('{8'h54}, 2, 32'h00000304);
        `CHK(la, 24'h020304)
        xfer('{8'h30}, 1, 32'h000000ff);
        wr(REG_INT_STATUS, 16'h0001);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        reset_to(1'b0);
        rd(REG_DBG_STATUS, 16'h0010);
        reset_to(1'b1);
        rd(4'hf, 16'h0000);
        t_pc();
        t_mem();
        t_chain();
        stp <= 1'b1;
        xfer('{OP_READ_STATUS}, 2, 32'h00000074);
        test_done();
    end
    // whole-run bound
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
